/* rtl/otpsc_regs.vh */
`ifndef OTPSC_REGS_VH
`define OTPSC_REGS_VH
// ----------------------------------------
// Word addresses inside the store.
// ----------------------------------------
`define OTPSC_ADDR_W 11
`define OTPSC_DATA_W 32
`define OTPSC_DEPTH 2048
`define OTPSC_TILE0_SEC_ADDR 11'h000
`define OTPSC_TILE1_SEC_UNI_ADDR 11'h001
`define OTPSC_USER_ID_ADDR 11'h004
`define OTPSC_UNI_USER_LO 11'h005
`define OTPSC_UNI_USER_HI 11'h7ff
`define OTPSC_T0_USER_LO 11'h005
`define OTPSC_T0_USER_HI 11'h3ff
`define OTPSC_SPLIT_RSVD_LO 11'h400
`define OTPSC_SPLIT_RSVD_HI 11'h404
`define OTPSC_TILE1_SEC_SPLIT_ADDR 11'h401
`define OTPSC_T1_USER_LO 11'h405
`define OTPSC_T1_USER_HI 11'h7ff
// ----------------------------------------
// Security word bit positions.
// ----------------------------------------
`define OTPSC_SEC_JTAG_OFF 0
`define OTPSC_SEC_PLL_OFF 4
`define OTPSC_SEC_SECURE_BOOT 5
`define OTPSC_SEC_UNIFIED 7
`define OTPSC_SEC_WRITE_OFF 8
`define OTPSC_SEC_READ_OFF 9
// ----------------------------------------
// User-ID field placement and blank value.
// ----------------------------------------
`define OTPSC_UID_SRC_HI 13
`define OTPSC_UID_W 14
`define OTPSC_BLANK_WORD 32'h0000_0000
`define OTPSC_REV_BITS 18'h0_0000
`endif

/* rtl/otpsc_mem.v */
`timescale 1ns/1ps
// ----------------------------------------
// One-time-programmable array.
// ----------------------------------------
// Bits only go from 0 to 1: a program ORs into the stored word.
module otpsc_mem #(
    parameter AW = 11,
    parameter DW = 32,
    parameter DEPTH = 1024
) (
    // Clock
    input wire clk_i,
    input wire ce_i,
    // Access
    input wire rd_i,
    input wire wr_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] wdata_i,
    output reg [DW-1:0] rdata_o
);
    reg [DW-1:0] mem [0:DEPTH-1];
    integer k;
    initial begin
        for (k = 0; k < DEPTH; k = k + 1) begin
            mem[k] = {DW{1'b0}};
        end
    end
    always @(posedge clk_i) begin
        if (ce_i) begin
            if (wr_i) begin
                mem[addr_i] <= mem[addr_i] | wdata_i;
            end
            if (rd_i) begin
                rdata_o <= mem[addr_i];
            end
        end
    end
endmodule // otpsc_mem

/* rtl/otpsc_top.v */
`timescale 1ns/1ps
`include "otpsc_regs.vh"
// How it works
// [R1] 4KB of one-time storage per tile for configuration, code and data.
// [R2] Tile 0 security comes from word 0x000, one disable per bit.
// [R3] Unified mode: tile 1 security comes from word 0x001.
// [R4] Word 0x004 bits 13:0 feed user-code bits 31:18.
// [R5] Unified mode: words 0x005 to 0x7ff are one shared user area.
// [R6] Split mode: words 0x005 to 0x3ff belong to tile 0.
// [R7] Split mode: words 0x405 to 0x7ff belong to tile 1.
// [R8] Split mode: tile 1 security from 0x401, word 0x400 unused.
// [R9] Security bit 0 blocks all debug access to the tile.
// [R10] Security bit 4 blocks debug access to the clock-generator register.
// [R11] Security bit 5 forces boot from store address 0.
// [R12] Security bit 7 merges halves; 0x400-0x404 ignored, 0x001 honoured.
// [R13] Bit 8 blocks programming; bit 9 blocks reads.
// [R14] Programming happens only through the three programming ports.
// [R15] User-ID field is loaded after reset release, invalid during reset.
// [R16] Blank bits read zero: everything enabled, split mode.
// [R17] Security words sampled once after reset, held until next reset.
module otpsc_top #(
    parameter AW = `OTPSC_ADDR_W,
    parameter DW = `OTPSC_DATA_W,
    parameter DEPTH = `OTPSC_DEPTH
) (
    // Clock and reset
    input wire CLK_I,
    input wire SRST_I,
    input wire CE_I,
    // Programming port 0: address and command
    input wire [AW-1:0] PGM_ADDR_I,
    input wire PGM_WR_I,
    input wire PGM_RD_I,
    input wire [1:0] PGM_TILE_I,
    // Programming port 1: write data
    input wire [DW-1:0] PGM_WDATA_I,
    // Programming port 2: read data and status
    output reg [DW-1:0] PGM_RDATA_O,
    output reg PGM_DONE_O,
    output reg PGM_DENIED_O,
    // Boot and debug path
    output reg CFG_VALID_O,
    output reg [DW-1:0] TILE0_SEC_O,
    output reg [DW-1:0] TILE1_SEC_O,
    output reg UNIFIED_O,
    output reg TILE0_JTAG_BLOCK_O,
    output reg TILE1_JTAG_BLOCK_O,
    output reg PLL_JTAG_BLOCK_O,
    output reg TILE0_SECURE_BOOT_O,
    output reg TILE1_SECURE_BOOT_O,
    output reg [DW-1:0] USERCODE_O
);
    // ----------------------------------------
    // Loader states.
    // ----------------------------------------
    localparam ST_RD0 = 3'd0;
    localparam ST_RD1 = 3'd1;
    localparam ST_RD1S = 3'd2;
    localparam ST_RDU = 3'd3;
    localparam ST_LAST = 3'd4;
    localparam ST_RUN = 3'd5;
    localparam ST_ACC = 3'd6;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [DW-1:0] sec0_reg;
    reg [DW-1:0] sec1u_reg;
    reg mem_rd;
    reg mem_wr;
    reg [AW-1:0] mem_addr;
    reg acc_wr_reg;
    reg [AW-1:0] acc_addr_reg;
    reg [DW-1:0] acc_data_reg;
    reg acc_tile_reg;
    reg rd_pend_reg;
    wire [DW-1:0] mem_rdata;
    wire [DW-1:0] tile1_word;
    wire unified;
    wire wr_off;
    wire rd_off;
    wire in_area;
    wire is_cfg;

    // ----------------------------------------
    // Storage.
    // ----------------------------------------
    otpsc_mem #(
        .AW(AW),
        .DW(DW),
        .DEPTH(DEPTH)
    ) u_mem (
        .clk_i(CLK_I),
        .ce_i(CE_I),
        .rd_i(mem_rd),
        .wr_i(mem_wr),
        .addr_i(mem_addr),
        .wdata_i(acc_data_reg),
        .rdata_o(mem_rdata)
    ); // see [R1]

    // Split mode is the blank default, so tile 0 bit 7 decides.
    assign unified = sec0_reg[`OTPSC_SEC_UNIFIED]; // see [R12] see [R16]
    // Unified mode ignores 0x400-0x404 and uses 0x001.
    assign tile1_word = unified ? sec1u_reg : mem_rdata; // see [R12]
    // Either tile's lock word restricts the shared array.
    assign wr_off = TILE0_SEC_O[`OTPSC_SEC_WRITE_OFF] |
                    TILE1_SEC_O[`OTPSC_SEC_WRITE_OFF]; // see [R13]
    assign rd_off = TILE0_SEC_O[`OTPSC_SEC_READ_OFF] |
                    TILE1_SEC_O[`OTPSC_SEC_READ_OFF]; // see [R13]
    // Configuration words stay programmable; area checks guard user words.
    assign is_cfg = (acc_addr_reg <= `OTPSC_USER_ID_ADDR) ||
                    (acc_addr_reg == `OTPSC_TILE1_SEC_SPLIT_ADDR);
    assign in_area = unified ?
        (acc_addr_reg >= `OTPSC_UNI_USER_LO) : // see [R5]
        (acc_tile_reg ?
            (acc_addr_reg >= `OTPSC_T1_USER_LO) : // see [R7]
            (acc_addr_reg >= `OTPSC_T0_USER_LO &&
             acc_addr_reg <= `OTPSC_T0_USER_HI)); // see [R6]

    // ----------------------------------------
    // Next state and array control.
    // ----------------------------------------
    always @* begin
        state_next = state_reg;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_addr = acc_addr_reg;
        case (state_reg)
            ST_RD0: begin
                mem_rd = 1'b1;
                mem_addr = `OTPSC_TILE0_SEC_ADDR; // see [R2]
                state_next = ST_RD1;
            end
            ST_RD1: begin
                mem_rd = 1'b1;
                mem_addr = `OTPSC_TILE1_SEC_UNI_ADDR; // see [R3]
                state_next = ST_RD1S;
            end
            ST_RD1S: begin
                mem_rd = 1'b1;
                mem_addr = `OTPSC_TILE1_SEC_SPLIT_ADDR; // see [R8]
                state_next = ST_RDU;
            end
            ST_RDU: begin
                mem_rd = 1'b1;
                mem_addr = `OTPSC_USER_ID_ADDR; // see [R4]
                state_next = ST_LAST;
            end
            ST_LAST: begin
                state_next = ST_RUN;
            end
            ST_RUN: begin
                if (PGM_WR_I || PGM_RD_I) begin
                    state_next = ST_ACC;
                end
            end
            ST_ACC: begin
                // Only the programming ports reach the array here.
                mem_wr = acc_wr_reg && !wr_off && (in_area || is_cfg); // see [R14]
                mem_rd = !acc_wr_reg && !rd_off && in_area; // see [R14]
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_RD0;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer and held configuration.
    // ----------------------------------------
    // Flags change only at the loader's end, so a program after boot
    // takes effect at the next reset, not mid-run.
    always @(posedge CLK_I) begin
        if (SRST_I) begin
            state_reg <= ST_RD0;
            sec0_reg <= `OTPSC_BLANK_WORD;
            sec1u_reg <= `OTPSC_BLANK_WORD;
            acc_wr_reg <= 1'b0;
            acc_addr_reg <= {AW{1'b0}};
            acc_data_reg <= {DW{1'b0}};
            acc_tile_reg <= 1'b0;
            CFG_VALID_O <= 1'b0;
            TILE0_SEC_O <= `OTPSC_BLANK_WORD;
            TILE1_SEC_O <= `OTPSC_BLANK_WORD;
            UNIFIED_O <= 1'b0;
            TILE0_JTAG_BLOCK_O <= 1'b0;
            TILE1_JTAG_BLOCK_O <= 1'b0;
            PLL_JTAG_BLOCK_O <= 1'b0;
            TILE0_SECURE_BOOT_O <= 1'b0;
            TILE1_SECURE_BOOT_O <= 1'b0;
            USERCODE_O <= {`OTPSC_BLANK_WORD}; // see [R15]
            PGM_RDATA_O <= {DW{1'b0}};
            PGM_DONE_O <= 1'b0;
            PGM_DENIED_O <= 1'b0;
        end else if (CE_I) begin
            state_reg <= state_next;
            PGM_DONE_O <= 1'b0;
            case (state_reg)
                ST_RD1: begin
                    sec0_reg <= mem_rdata;
                end
                ST_RD1S: begin
                    sec1u_reg <= mem_rdata;
                end
                ST_RDU: begin
                    // Words and flags load together so they never disagree.
                    TILE0_SEC_O <= sec0_reg; // see [R17]
                    TILE1_SEC_O <= tile1_word; // see [R12]
                    UNIFIED_O <= unified;
                    TILE0_JTAG_BLOCK_O <= sec0_reg[`OTPSC_SEC_JTAG_OFF]; // see [R9]
                    TILE1_JTAG_BLOCK_O <= tile1_word[`OTPSC_SEC_JTAG_OFF]; // see [R9]
                    PLL_JTAG_BLOCK_O <= sec0_reg[`OTPSC_SEC_PLL_OFF]; // see [R10]
                    TILE0_SECURE_BOOT_O <= sec0_reg[`OTPSC_SEC_SECURE_BOOT]; // see [R11]
                    TILE1_SECURE_BOOT_O <= tile1_word[`OTPSC_SEC_SECURE_BOOT]; // see [R11]
                end
                ST_LAST: begin
                    USERCODE_O <= {mem_rdata[`OTPSC_UID_SRC_HI:0],
                                   `OTPSC_REV_BITS}; // see [R4] see [R15]
                    CFG_VALID_O <= 1'b1;
                end
                ST_RUN: begin
                    acc_wr_reg <= PGM_WR_I;
                    acc_addr_reg <= PGM_ADDR_I;
                    acc_data_reg <= PGM_WDATA_I;
                    acc_tile_reg <= PGM_TILE_I[0];
                end
                ST_ACC: begin
                    PGM_DONE_O <= 1'b1;
                    PGM_DENIED_O <= acc_wr_reg ? (wr_off || !(in_area || is_cfg)) :
                                                 (rd_off || !in_area); // see [R13]
                end
                default: begin
                end
            endcase
            // Read data arrive the cycle after the done pulse.
            if (rd_pend_reg) begin
                PGM_RDATA_O <= mem_rdata;
            end
            if (state_reg == ST_RUN && PGM_RD_I && !PGM_WR_I) begin
                PGM_RDATA_O <= {DW{1'b0}};
            end
            if (state_reg == ST_LAST) begin
                PGM_RDATA_O <= {DW{1'b0}};
            end
        end
    end

    // Read data returns two cycles after the access cycle.
    always @(posedge CLK_I) begin
        if (SRST_I) begin
            rd_pend_reg <= 1'b0;
        end else if (CE_I) begin
            rd_pend_reg <= (state_reg == ST_ACC) && mem_rd;
        end
    end
endmodule // otpsc_top

/* sim/otpsc_boot_model.sv */
`timescale 1ns/1ps
// ----
// Tile boot logic and debug access path.
// ----
// Code 2'b11 means boot from the store; the strap value is used otherwise.
module otpsc_boot_model (
    input wire tile0_secure_i,
    input wire tile1_secure_i,
    input wire pll_block_i,
    input wire [1:0] ext_sel_i,
    output wire [1:0] boot0_src_o,
    output wire [1:0] boot1_src_o,
    output wire pll_access_ok_o
);
    assign boot0_src_o = tile0_secure_i ? 2'b11 : ext_sel_i;
    assign boot1_src_o = tile1_secure_i ? 2'b11 : ext_sel_i;
    // A blocked path refuses reads and writes alike, so one flag is enough.
    assign pll_access_ok_o = !pll_block_i;
endmodule // otpsc_boot_model

/* sim/otpsc_monitor.sv */
`timescale 1ns/1ps
// ----
// Port checks.
// ----
module otpsc_monitor #(parameter AW = 11, parameter DW = 32, parameter DEPTH = 2048) (
    // Inputs of the block
    input wire CLK_I, SRST_I, CE_I, PGM_WR_I, PGM_RD_I,
    input wire [AW-1:0] PGM_ADDR_I,
    input wire [1:0] PGM_TILE_I,
    input wire [DW-1:0] PGM_WDATA_I,
    // Outputs of the block
    input wire [DW-1:0] PGM_RDATA_O, TILE0_SEC_O, TILE1_SEC_O, USERCODE_O,
    input wire PGM_DONE_O, PGM_DENIED_O, CFG_VALID_O, UNIFIED_O,
    input wire TILE0_JTAG_BLOCK_O, TILE1_JTAG_BLOCK_O, PLL_JTAG_BLOCK_O,
    input wire TILE0_SECURE_BOOT_O, TILE1_SECURE_BOOT_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    chk_reset_quiet: assert property (disable iff (1'b0) SRST_I && CE_I |=>
        !CFG_VALID_O && USERCODE_O == 0 && !PGM_DONE_O) else $error("outputs live in reset");
    chk_valid_delay: assert property ($fell(SRST_I) |-> ##[3:7] CFG_VALID_O)
        else $error("config load late");
    chk_usercode_low: assert property (USERCODE_O[17:0] == 0)
        else $error("usercode low bits set");
    chk_jtag_bits: assert property (TILE0_JTAG_BLOCK_O == TILE0_SEC_O[0] &&
        TILE1_JTAG_BLOCK_O == TILE1_SEC_O[0]) else $error("debug block flag wrong");
    chk_pll_boot: assert property (PLL_JTAG_BLOCK_O == TILE0_SEC_O[4] &&
        TILE0_SECURE_BOOT_O == TILE0_SEC_O[5] && TILE1_SECURE_BOOT_O == TILE1_SEC_O[5])
        else $error("clock or boot flag wrong");
    chk_unified_bit: assert property (UNIFIED_O == TILE0_SEC_O[7])
        else $error("unified flag wrong");
    chk_sec_held: assert property (CFG_VALID_O && $past(CFG_VALID_O) |->
        $stable(TILE0_SEC_O) && $stable(TILE1_SEC_O) && $stable(USERCODE_O))
        else $error("config changed before reset");
    chk_done_pulse: assert property (PGM_DONE_O |=> !PGM_DONE_O)
        else $error("done longer than one cycle");
    chk_done_delay: assert property ($rose(PGM_WR_I || PGM_RD_I) && CFG_VALID_O
        |-> !PGM_DONE_O ##2 PGM_DONE_O) else $error("done not two cycles after request");
    chk_lock_deny: assert property ($rose(PGM_WR_I) && CFG_VALID_O &&
        (TILE0_SEC_O[8] || TILE1_SEC_O[8]) |-> ##2 PGM_DENIED_O) else $error("locked write ok");
endmodule // otpsc_monitor
bind otpsc_top otpsc_monitor #(.AW(AW), .DW(DW), .DEPTH(DEPTH)) mon (.*);

/* sim/test_otpsc_top.sv */
`timescale 1ns/1ps
module test_otpsc_top;
    reg CLK_I = 0, SRST_I = 1, CE_I = 1, PGM_WR_I = 0, PGM_RD_I = 0;
    reg [10:0] PGM_ADDR_I = 0;
    reg [1:0] PGM_TILE_I = 0, ext_sel = 2'b01;
    reg [31:0] PGM_WDATA_I = 0, rnd = 32'hbedc, uid, w405;
    wire [31:0] PGM_RDATA_O, TILE0_SEC_O, TILE1_SEC_O, USERCODE_O;
    wire PGM_DONE_O, PGM_DENIED_O, CFG_VALID_O, UNIFIED_O, PLL_JTAG_BLOCK_O, pll_ok;
    wire TILE0_JTAG_BLOCK_O, TILE1_JTAG_BLOCK_O, TILE0_SECURE_BOOT_O, TILE1_SECURE_BOOT_O;
    wire [1:0] boot0, boot1;
    int miscompares = 0, num_checks = 0;
    bit exp_q[$];
    initial forever #10 CLK_I = ~CLK_I;
    otpsc_top dut (.*);
    otpsc_boot_model partner (.tile0_secure_i(TILE0_SECURE_BOOT_O),
        .tile1_secure_i(TILE1_SECURE_BOOT_O), .pll_block_i(PLL_JTAG_BLOCK_O),
        .ext_sel_i(ext_sel), .boot0_src_o(boot0), .boot1_src_o(boot1), .pll_access_ok_o(pll_ok));
    function [31:0] rn();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd;
    endfunction
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task fail(input string m);
        miscompares++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task cmp_word(input [31:0] g, input [31:0] e);
        num_checks++;
        if (g !== e) fail("config output mismatch");
    endtask
    // A wait that runs out still ends the run through the one verdict.
    task rst(input int n);
        int k;
        SRST_I <= 1;
        repeat (n) @(posedge CLK_I);
        SRST_I <= 0;
        for (k = 0; k < 12 && CFG_VALID_O !== 1'b1; k++) @(posedge CLK_I);
        if (k == 12) begin
            fail("config never valid");
            finish_test;
        end
    endtask
    task acc(input w, input [10:0] a, input [31:0] d, input [1:0] t, input den);
        int k;
        exp_q.push_back(den);
        @(posedge CLK_I);
        PGM_WR_I <= w;
        PGM_RD_I <= !w;
        PGM_ADDR_I <= a;
        PGM_WDATA_I <= d;
        PGM_TILE_I <= t;
        @(posedge CLK_I);
        PGM_WR_I <= 0;
        PGM_RD_I <= 0;
        for (k = 0; k < 8 && PGM_DONE_O !== 1'b1; k++) @(posedge CLK_I);
        if (k == 8) begin
            fail("no done");
            finish_test;
        end
        @(posedge CLK_I);
    endtask
    always @(posedge CLK_I) begin
        if (PGM_DONE_O === 1'b1) begin
            num_checks++;
            if (exp_q.size() == 0) fail("unexpected done");
            else if (PGM_DENIED_O !== exp_q.pop_front()) fail("denied flag mismatch");
        end
    end
    initial begin
        rst(12);
        cmp_word(TILE0_SEC_O | TILE1_SEC_O, 32'h0000_0000);
        cmp_word({31'h0, UNIFIED_O}, 32'h0000_0000);
        uid = rn();
        acc(1, 11'h004, uid, 0, 0);
        acc(1, 11'h401, 32'h0000_0001, 0, 0);
        acc(1, 11'h000, 32'h0000_0031, 0, 0);
        acc(1, 11'h3ff, rn(), 0, 0);
        acc(1, 11'h405, rn(), 0, 1);
        w405 = rn();
        acc(1, 11'h405, w405, 1, 0);
        acc(1, 11'h005, rn(), 1, 1);
        acc(0, 11'h405, 0, 1, 0);
        cmp_word(PGM_RDATA_O, w405);
        acc(0, 11'h3ff, 0, 1, 1);
        cmp_word(PGM_RDATA_O, 32'h0000_0000);
        acc(1, 11'h400, rn(), 1, 1);
        cmp_word(TILE0_SEC_O, 32'h0000_0000);
        rst(2);
        cmp_word(TILE0_SEC_O, 32'h0000_0031);
        cmp_word(TILE1_SEC_O, 32'h0000_0001);
        cmp_word(USERCODE_O, {uid[13:0], 18'h0_0000});
        cmp_word({TILE0_JTAG_BLOCK_O, TILE1_JTAG_BLOCK_O, PLL_JTAG_BLOCK_O, pll_ok,
            TILE0_SECURE_BOOT_O, TILE1_SECURE_BOOT_O}, 32'h0000_003a);
        cmp_word({boot0, boot1}, 32'h0000_000d);
        acc(1, 11'h001, 32'h0000_0020, 0, 0);
        acc(1, 11'h000, 32'h0000_0080, 0, 0);
        rst(2);
        cmp_word(TILE1_SEC_O, 32'h0000_0020);
        cmp_word({31'h0, UNIFIED_O}, 32'h0000_0001);
        acc(1, 11'h7ff, rn(), 0, 0);
        acc(1, 11'h005, rn(), 1, 0);
        acc(1, 11'h000, 32'h0000_0300, 0, 0);
        rst(2);
        acc(1, 11'h7ff, rn(), 0, 1);
        acc(0, 11'h7ff, 0, 0, 1);
        cmp_word(PGM_RDATA_O, 32'h0000_0000);
        acc(1, 11'h004, rn(), 0, 1);
        repeat (4) @(posedge CLK_I);
        if (exp_q.size() != 0) fail("missing done");
        finish_test;
    end
endmodule // test_otpsc_top
